// >>> src/sep_eeprom.sv
// two-wire eeprom slave: page write, polling, reads, soft reset
`timescale 1ns/100ps
module sep_eeprom
	import sep_pkg::*;
#(
	parameter int PROG_CYCLES = SEP_PROG_CYCLES
)
(
	input  wire logic            clk,
	input  wire logic            rstn,
	input  wire logic            clk_en,
	input  wire sep_pkg::sep_bus_s bus_in,
	input  wire logic            select_bit_two,
	input  wire logic            write_guard,
	output sep_pkg::sep_drive_s  bus_out,
	output logic                 busy
);
	import sep_pkg::*;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_DEV,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA,
		ST_RACK
	} sep_state_e;

	// three stage pin sampling; the first stage feeds only the second
	logic [2:0]            scl_sync_reg;
	logic [2:0]            sda_sync_reg;
	logic                  scl_reg;
	logic                  sda_reg;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_det;
	logic                  stop_det;

	logic [7:0]            mem_reg [SEP_DEPTH];
	logic [7:0]            page_reg [SEP_PAGE_BYTES];
	logic [SEP_PAGE_BYTES-1:0] page_vld_reg;
	logic [SEP_ADDR_W-1:0] addr_reg;
	logic [SEP_ADDR_W-1:0] wstart_reg;
	logic [5:0]            wcount_reg;
	sep_state_e            state_reg;
	logic [3:0]            bit_reg;
	logic [7:0]            shift_reg;
	logic                  ack_phase_reg;
	logic                  prog_reg;
	logic [31:0]           prog_cnt_reg;
	logic [3:0]            rst_clk_reg;
	logic                  rst_arm_reg;
	logic                  sda_o_reg;
	logic                  sda_oe_reg;
	logic                  write_ok;
	logic                  dev_match;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_reg      <= 1'b1;
			sda_reg      <= 1'b1;
		end
		else if (clk_en)
		begin
			scl_sync_reg <= {scl_sync_reg[1:0], bus_in.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], bus_in.sda};
			if (scl_sync_reg[1] == scl_sync_reg[2])
				scl_reg <= scl_sync_reg[2];
			if (sda_sync_reg[1] == sda_sync_reg[2])
				sda_reg <= sda_sync_reg[2];
		end
	end

	assign scl_rise  = (scl_sync_reg[1] == scl_sync_reg[2])
		&& scl_sync_reg[2] && !scl_reg;
	assign scl_fall  = (scl_sync_reg[1] == scl_sync_reg[2])
		&& !scl_sync_reg[2] && scl_reg;
	assign start_det = scl_reg && !scl_fall && sda_reg
		&& (sda_sync_reg[1] == sda_sync_reg[2]) && !sda_sync_reg[2];
	assign stop_det  = scl_reg && !scl_fall && !sda_reg
		&& (sda_sync_reg[1] == sda_sync_reg[2]) && sda_sync_reg[2];

	assign dev_match = (shift_reg[7:4] == SEP_DEV_CODE)
		&& (shift_reg[3:1] == {select_bit_two, 2'b00});
	assign write_ok  = !write_guard;

	// programming timer; while it runs the whole bus is ignored
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prog_reg     <= 1'b0;
			prog_cnt_reg <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			if (prog_reg)
			begin
				if (prog_cnt_reg == 32'h0000_0000)
					prog_reg <= 1'b0;
				else
					prog_cnt_reg <= prog_cnt_reg - 32'h0000_0001;
			end
			else if (stop_det && state_reg == ST_WDATA
				&& wcount_reg != 6'h00 && write_ok)
			begin
				prog_reg     <= 1'b1;
				prog_cnt_reg <= 32'(PROG_CYCLES - 1);
			end
		end
	end

	assign busy = prog_reg;

	// array commit at end of programming, all received page bytes at once
	always_ff @(posedge clk)
	begin
		if (clk_en && prog_reg && prog_cnt_reg == 32'h0000_0000)
		begin
			for (int i = 0; i < SEP_PAGE_BYTES; i++)
				if (page_vld_reg[i])
					mem_reg[{wstart_reg[SEP_ADDR_W-1:SEP_PAGE_W],
						SEP_PAGE_W'(i)}] <= page_reg[i];
		end
	end

	// soft reset: start, nine clocks, start; dead while programming
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_arm_reg <= 1'b0;
			rst_clk_reg <= 4'h0;
		end
		else if (clk_en && !prog_reg)
		begin
			if (start_det)
			begin
				rst_arm_reg <= 1'b1;
				rst_clk_reg <= 4'h0;
			end
			else if (stop_det)
				rst_arm_reg <= 1'b0;
			else if (scl_rise && rst_arm_reg && rst_clk_reg != 4'hF)
				rst_clk_reg <= rst_clk_reg + 4'h1;
		end
	end

	// protocol engine: shift, ack, address counter and page buffer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg     <= ST_IDLE;
			bit_reg       <= 4'h0;
			shift_reg     <= 8'h00;
			ack_phase_reg <= 1'b0;
			addr_reg      <= SEP_ADDR_RST;
			wstart_reg    <= SEP_ADDR_RST;
			wcount_reg    <= 6'h00;
			page_vld_reg  <= '0;
			sda_o_reg     <= 1'b1;
			sda_oe_reg    <= 1'b0;
			for (int i = 0; i < SEP_PAGE_BYTES; i++)
				page_reg[i] <= SEP_BYTE_RST;
		end
		else if (clk_en && !prog_reg)
		begin
			if (start_det)
			begin
				// a repeated start also ends the soft reset sequence
				state_reg     <= ST_DEV;
				bit_reg       <= 4'h0;
				ack_phase_reg <= 1'b0;
				sda_oe_reg    <= 1'b0;
				sda_o_reg     <= 1'b1;
				if (state_reg == ST_WDATA && wcount_reg > 6'(SEP_PAGE_BYTES))
					addr_reg <= wstart_reg;
			end
			else if (stop_det)
			begin
				state_reg  <= ST_IDLE;
				sda_oe_reg <= 1'b0;
				sda_o_reg  <= 1'b1;
				if (state_reg == ST_WDATA && wcount_reg > 6'(SEP_PAGE_BYTES))
					addr_reg <= wstart_reg;
			end
			else if (state_reg != ST_IDLE && scl_rise)
			begin
				if (ack_phase_reg)
				begin
					if (state_reg == ST_RACK)
					begin
						if (sda_reg)
							state_reg <= ST_IDLE;
						else
							state_reg <= ST_RDATA;
					end
				end
				else if (state_reg != ST_RDATA && state_reg != ST_RACK)
				begin
					shift_reg <= {shift_reg[6:0], sda_reg};
					bit_reg   <= bit_reg + 4'h1;
				end
				else
					bit_reg <= bit_reg + 4'h1;
			end
			else if (state_reg != ST_IDLE && scl_fall)
			begin
				if (ack_phase_reg)
				begin
					// ack slot over: release or load read data
					ack_phase_reg <= 1'b0;
					sda_oe_reg <= 1'b0;
					sda_o_reg  <= 1'b1;
					if (state_reg == ST_RDATA)
					begin
						shift_reg  <= mem_reg[addr_reg];
						sda_oe_reg <= !mem_reg[addr_reg][7];
						sda_o_reg  <= mem_reg[addr_reg][7];
						bit_reg    <= 4'h0;
					end
					else
						bit_reg <= 4'h0;
				end
				else if (state_reg == ST_RDATA)
				begin
					if (bit_reg == 4'h8)
					begin
						sda_oe_reg    <= 1'b0;
						sda_o_reg     <= 1'b1;
						state_reg     <= ST_RACK;
						ack_phase_reg <= 1'b1;
						addr_reg      <= addr_reg + 13'h0001;
					end
					else
					begin
						sda_oe_reg <= !shift_reg[7 - bit_reg[2:0]];
						sda_o_reg  <= shift_reg[7 - bit_reg[2:0]];
					end
				end
				else if (bit_reg == 4'h8)
				begin
					ack_phase_reg <= 1'b1;
					case (state_reg)
						ST_DEV:
						begin
							if (dev_match && rst_clk_reg != 4'(SEP_RESET_CLKS))
							begin
								// busy case never reached, bus frozen
								if (shift_reg[0])
									state_reg <= ST_RDATA;
								else
									state_reg <= ST_ADDR_HI;
							end
							else
							begin
								state_reg     <= ST_IDLE;
							end
						end
						ST_ADDR_HI:
						begin
							wstart_reg[SEP_ADDR_W-1:8] <=
								shift_reg[SEP_ADDR_W-9:0];
							state_reg <= ST_ADDR_LO;
						end
						ST_ADDR_LO:
						begin
							addr_reg      <= {wstart_reg[SEP_ADDR_W-1:8],
								shift_reg};
							wstart_reg[7:0] <= shift_reg;
							wcount_reg    <= 6'h00;
							page_vld_reg  <= '0;
							state_reg     <= ST_WDATA;
						end
						ST_WDATA:
						begin
							page_reg[addr_reg[SEP_PAGE_W-1:0]] <= shift_reg;
							page_vld_reg[addr_reg[SEP_PAGE_W-1:0]] <= 1'b1;
							addr_reg[SEP_PAGE_W-1:0] <=
								addr_reg[SEP_PAGE_W-1:0] + 5'h01;
							if (wcount_reg != 6'h3F)
								wcount_reg <= wcount_reg + 6'h01;
						end
						default:
						begin
							state_reg <= ST_IDLE;
						end
					endcase
					if (state_reg == ST_DEV && !(dev_match
						&& rst_clk_reg != 4'(SEP_RESET_CLKS)))
					begin
						sda_oe_reg <= 1'b0;
						sda_o_reg  <= 1'b1;
					end
					else
					begin
						sda_oe_reg <= 1'b1;
						sda_o_reg  <= 1'b0;
					end
				end
			end
		end
	end

	assign bus_out.sda_o  = sda_o_reg;
	assign bus_out.sda_oe = sda_oe_reg;
endmodule

// >>> src/sep_pkg.sv
// shared constants and types for the serial eeprom slave
package sep_pkg;
	localparam int          SEP_ADDR_W       = 13;
	localparam int          SEP_DEPTH        = 8192;
	localparam int          SEP_PAGE_BYTES   = 32;
	localparam int          SEP_PAGE_W       = 5;
	localparam logic [3:0]  SEP_DEV_CODE     = 4'hA;
	localparam logic [12:0] SEP_ADDR_RST     = 13'h0000;
	localparam logic [7:0]  SEP_BYTE_RST     = 8'hFF;
	localparam int          SEP_PROG_TIME_MS = 5;
	localparam int          SEP_CLK_MHZ      = 100;
	localparam int          SEP_PROG_CYCLES  =
		SEP_PROG_TIME_MS * 1000 * SEP_CLK_MHZ;
	localparam int          SEP_RESET_CLKS   = 9;

	typedef struct packed
	{
		logic scl;
		logic sda;
	} sep_bus_s;

	typedef struct packed
	{
		logic sda_o;
		logic sda_oe;
	} sep_drive_s;
endpackage

// >>> verification/sep_eeprom_asserts.sv
// port checks for the eeprom slave
`timescale 1ns/100ps
module sep_eeprom_asserts
	import sep_pkg::*;
#(
	parameter int PROG_CYCLES = SEP_PROG_CYCLES
)
(
	input wire logic               clk,
	input wire logic               rstn,
	input wire logic               clk_en,
	input wire sep_pkg::sep_bus_s   bus_in,
	input wire logic               select_bit_two,
	input wire logic               write_guard,
	input wire sep_pkg::sep_drive_s bus_out,
	input wire logic               busy
);
	int cnt;
	// length of the current programming cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt <= 0;
		else
			cnt <= busy ? cnt + 1 : 0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_ack_drives_low: assert property (
		bus_out.sda_oe |-> !bus_out.sda_o) else $error("data driven high");
	a_busy_no_ack: assert property (
		busy |-> !bus_out.sda_oe) else $error("answer while programming");
	a_prog_length: assert property (
		$fell(busy) |-> cnt == PROG_CYCLES) else $error("program time off");
	a_prog_bound: assert property (
		busy |-> cnt < PROG_CYCLES) else $error("program cycle too long");
	a_guard_blocks: assert property (
		write_guard && !busy |=> !busy) else $error("guarded write ran");
	a_busy_entry: assert property (
		$rose(busy) |-> bus_in.scl && bus_in.sda)
		else $error("programming without stop");
	a_oe_scl_low: assert property (
		$changed(bus_out.sda_oe) |-> !bus_in.scl)
		else $error("data changed with clock high");
	a_release_idle: assert property (
		$rose(rstn) |-> !busy && !bus_out.sda_oe)
		else $error("not idle after reset");
endmodule
bind sep_eeprom sep_eeprom_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
	.clk(clk), .rstn(rstn), .clk_en(clk_en), .bus_in(bus_in),
	.select_bit_two(select_bit_two), .write_guard(write_guard),
	.bus_out(bus_out), .busy(busy));

// >>> verification/sep_eeprom_bench.sv
// self-checking bench for the eeprom slave
`timescale 1ns/100ps
`define CK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module sep_eeprom_bench;
	import sep_pkg::*;
	localparam int PC = 200;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        sel = 1'b1;
	logic        guard = 1'b0;
	logic        scl, rel, k, busy;
	sep_bus_s    bi;
	sep_drive_s  bo;
	logic [31:0] seed = 32'hF758035D;
	logic [7:0]  em [0:8191];
	logic [12:0] ctr = 13'h0000;
	logic [12:0] a;
	int          n_errors = 0;
	int          check_count = 0;
	assign bi.scl = scl;
	assign bi.sda = rel & ~(bo.sda_oe & ~bo.sda_o);
	always #5 clk = ~clk;
	sep_master m (.scl(scl), .sda_rel(rel), .sda(bi.sda));
	sep_eeprom #(.PROG_CYCLES(PC)) uut (.clk(clk), .rstn(rstn),
		.clk_en(1'b1), .bus_in(bi), .select_bit_two(sel),
		.write_guard(guard), .bus_out(bo), .busy(busy));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] dev(input logic r);
		return {SEP_DEV_CODE, sel, 2'b00, r};
	endfunction
	function automatic logic [12:0] inp(input logic [12:0] x, input int i);
		return {x[12:5], x[4:0] + 5'(i)};
	endfunction
	task automatic hdr(input logic [12:0] x);
		m.start();
		m.wb(dev(1'b0), k);
		`CK(k, 1'b0)
		m.wb({3'h0, x[12:8]}, k);
		`CK(k, 1'b0)
		m.wb(x[7:0], k);
		`CK(k, 1'b0)
	endtask
	task automatic poll(input logic exp);
		m.start();
		m.wb(dev(1'b0), k);
		`CK(k, exp)
		m.stop();
	endtask
	task automatic wr(input logic [12:0] x, input int n);
		logic [7:0] d;
		hdr(x);
		for (int i = 0; i < n; i++)
		begin
			seed = nx(seed);
			d = seed[7:0];
			if (!guard)
				em[inp(x, i)] = d;
			m.wb(d, k);
			`CK(k, 1'b0)
		end
		m.stop();
		ctr = (n > 32) ? x : inp(x, n);
		`CK(busy, !guard)
		if (busy)
			poll(1'b1);
		for (int j = 0; j < PC + 50 && busy; j++)
			@(negedge clk);
		`CK(busy, 1'b0)
		poll(1'b0);
	endtask
	task automatic rd(input logic cur, input logic [12:0] x, input int n);
		logic [7:0]  d;
		logic [12:0] ad;
		ad = cur ? ctr : x;
		if (!cur)
			hdr(x);
		m.start();
		m.wb(dev(1'b1), k);
		`CK(k, 1'b0)
		for (int i = 0; i < n; i++)
		begin
			m.rb(i == n - 1, d);
			`CK(d, em[ad])
			ad = ad + 13'h0001;
		end
		m.stop();
		ctr = ad;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		n_errors++;
		conclude();
	end
	initial
	begin
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		repeat (5) @(negedge clk);
		seed = nx(seed);
		a = {seed[12:5], 5'h03};
		wr(a, 4);
		rd(1'b0, a, 3);
		rd(1'b1, a, 1);
		$display("test page write done");
		seed = nx(seed);
		a = {seed[12:5], 5'h1E};
		wr(a, 4);
		wr({a[12:5], 5'h1F}, 1);
		rd(1'b1, a, 2);
		seed = nx(seed);
		a = {seed[12:5], 5'h00};
		wr(a, 34);
		rd(1'b1, a, 2);
		$display("test page wrap done");
		wr(13'h1FFF, 1);
		wr(13'h0000, 1);
		rd(1'b0, 13'h1FFF, 1);
		m.start();
		m.wb(dev(1'b0), k);
		m.wb(8'h05, k);
		m.start();
		repeat (9) m.bit_io(1'b1, k);
		rd(1'b1, a, 1);
		rd(1'b0, 13'h1FFF, 2);
		$display("test reads done");
		@(negedge clk) guard = 1'b1;
		wr(13'h0000, 1);
		@(negedge clk) guard = 1'b0;
		rd(1'b0, 13'h0000, 1);
		m.start();
		m.wb({SEP_DEV_CODE, ~sel, 3'b000}, k);
		`CK(k, 1'b1)
		m.stop();
		$display("test guard and select done");
		conclude();
	end
endmodule

// >>> verification/sep_master.sv
// bus master model; data released to the pull-up
`timescale 1ns/100ps
module sep_master
(
	output logic      scl,
	output logic      sda_rel,
	input  wire logic sda
);
	localparam realtime Q = 31.25;
	initial
	begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// clock idles high, stands still between frames
	task automatic bit_io(input logic b, output logic r);
		sda_rel = b;
		#Q scl = 1'b1;
		#(2 * Q) r = sda;
		scl = 1'b0;
		#Q;
	endtask
	task automatic start();
		sda_rel = 1'b1;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_rel = 1'b0;
		#Q scl = 1'b1;
		#Q sda_rel = 1'b1;
		#(2 * Q);
	endtask
	task automatic wb(input logic [7:0] d, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, a);
	endtask
	task automatic rb(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, r);
	endtask
endmodule
